// ===== verilog/srr_status_regs.sv
`timescale 1ns/1ns
`include "srr_defs.svh"

module srr_status_regs (
  input  wire logic              sys_clk,
  input  wire logic              rst,
  input  wire logic              cmd_valid,
  input  srr_pkg::srr_cmd_e      cmd_code,
  input  wire logic [15:0]       cmd_data,
  input  wire logic              const_current_active,
  input  wire logic              const_voltage_active,
  input  wire logic              awaiting_trigger,
  input  wire logic              cal_computing,
  input  wire logic              overtemp_flag,
  output logic                   rsp_valid,
  output logic [15:0]            rsp_data,
  output logic [7:0]             status_byte,
  output logic [4:0]             bus_address,
  output logic                   beep_tone,
  output logic [15:0]            volt_setting,
  output logic [15:0]            volt_limit,
  output logic                   err_post,
  output logic [15:0]            err_code
);

  // ****************************************************************
  // command decode
  // ****************************************************************
  function automatic logic cmd_is(input logic v, input srr_pkg::srr_cmd_e c,
                                  input srr_pkg::srr_cmd_e want);
    cmd_is = v && (c == want);
  endfunction : cmd_is

  function automatic logic [15:0] rise(input logic [15:0] now, input logic [15:0] prev,
                                       input logic [15:0] used);
    rise = now & ~prev & used;
  endfunction : rise

  logic        preset;
  logic        oper_evt_rd;
  logic        ques_evt_rd;
  logic        oper_mask_wr;
  logic        ques_mask_wr;
  logic        addr_wr;
  logic        volt_wr;
  logic        vlim_wr;
  logic        beep_cmd;
  logic        addr_ok;
  logic        volt_ok;
  logic [15:0] volt_limit_q;

  assign preset       = cmd_is(cmd_valid, cmd_code, srr_pkg::SRR_PRESET);
  assign oper_evt_rd  = cmd_is(cmd_valid, cmd_code, srr_pkg::SRR_OPER_EVT_RD);
  assign ques_evt_rd  = cmd_is(cmd_valid, cmd_code, srr_pkg::SRR_QUES_EVT_RD);
  assign oper_mask_wr = cmd_is(cmd_valid, cmd_code, srr_pkg::SRR_OPER_ENAB_WR);
  assign ques_mask_wr = cmd_is(cmd_valid, cmd_code, srr_pkg::SRR_QUES_ENAB_WR);
  assign addr_wr      = cmd_is(cmd_valid, cmd_code, srr_pkg::SRR_ADDR_WR);
  assign volt_wr      = cmd_is(cmd_valid, cmd_code, srr_pkg::SRR_VOLT_WR);
  assign vlim_wr      = cmd_is(cmd_valid, cmd_code, srr_pkg::SRR_VLIM_WR);
  assign beep_cmd     = cmd_is(cmd_valid, cmd_code, srr_pkg::SRR_BEEP);
  assign addr_ok      = (cmd_data[15:5] == 11'h000) && (cmd_data[4:0] >= `SRR_ADDR_MIN)
                        && (cmd_data[4:0] <= `SRR_ADDR_MAX);
  assign volt_ok      = cmd_data <= volt_limit_q;

  // ****************************************************************
  // live condition vectors
  // ****************************************************************
  logic [15:0] oper_live;
  logic [15:0] ques_live;
  logic [15:0] oper_prev_q;
  logic [15:0] ques_prev_q;
  logic [15:0] oper_rise;
  logic [15:0] ques_rise;

  // unused positions are tied low here, so nothing downstream can set them
  always_comb
  begin
    oper_live = 16'h0000;
    oper_live[`SRR_OPER_IREG_BIT]      = const_current_active;
    oper_live[`SRR_OPER_VREG_BIT]      = const_voltage_active;
    oper_live[`SRR_OPER_TRIG_WAIT_BIT] = awaiting_trigger;
    oper_live[`SRR_OPER_CAL_BIT]       = cal_computing;
    ques_live = 16'h0000;
    ques_live[`SRR_QUES_OVERTEMP_BIT]  = overtemp_flag;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      oper_prev_q <= 16'h0000;
      ques_prev_q <= 16'h0000;
    end
    else
    begin
      oper_prev_q <= oper_live;
      ques_prev_q <= ques_live;
    end
  end

  assign oper_rise = rise(oper_live, oper_prev_q, `SRR_OPER_USED_MASK);
  assign ques_rise = rise(ques_live, ques_prev_q, `SRR_QUES_USED_MASK);

  // ****************************************************************
  // latched event registers
  // ****************************************************************
  logic [15:0] oper_evt;
  logic [15:0] ques_evt;

  // a rise in the read or preset cycle survives: set beats clear
  for (genvar gi = 0; gi < 16; gi++)
  begin : g_evt
    logic oper_bit_q;
    logic ques_bit_q;
    always_ff @(posedge sys_clk)
    begin
      if (rst)
        oper_bit_q <= 1'b0;
      else if (oper_rise[gi])
        oper_bit_q <= 1'b1;
      else if (oper_evt_rd || preset)
        oper_bit_q <= 1'b0;
    end
    always_ff @(posedge sys_clk)
    begin
      if (rst)
        ques_bit_q <= 1'b0;
      else if (ques_rise[gi])
        ques_bit_q <= 1'b1;
      else if (ques_evt_rd || preset)
        ques_bit_q <= 1'b0;
    end
    assign oper_evt[gi] = oper_bit_q;
    assign ques_evt[gi] = ques_bit_q;
  end

  // ****************************************************************
  // enable masks
  // ****************************************************************
  logic [15:0] oper_mask_q;
  logic [15:0] ques_mask_q;

  always_ff @(posedge sys_clk)
  begin
    if (rst || preset)
      oper_mask_q <= `SRR_MASK_RESET;
    else if (oper_mask_wr)
      oper_mask_q <= cmd_data & `SRR_OPER_USED_MASK;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst || preset)
      ques_mask_q <= `SRR_MASK_RESET;
    else if (ques_mask_wr)
      ques_mask_q <= cmd_data & `SRR_QUES_USED_MASK;
  end

  // ****************************************************************
  // status byte summaries
  // ****************************************************************
  logic [7:0] status_q;

  // one cycle behind the event registers, traded for a registered output
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      status_q <= 8'h00;
    else
    begin
      status_q                    <= 8'h00;
      status_q[`SRR_STB_OPER_BIT] <= |(oper_evt & oper_mask_q);
      status_q[`SRR_STB_QUES_BIT] <= |(ques_evt & ques_mask_q);
    end
  end

  // ****************************************************************
  // system settings
  // ****************************************************************
  logic [4:0]  addr_q;
  logic [15:0] volt_q;
  logic        err_post_q;
  logic [15:0] err_code_q;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      addr_q <= `SRR_ADDR_RESET;
    else if (addr_wr && addr_ok)
      addr_q <= cmd_data[4:0];
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      volt_limit_q <= `SRR_VLIM_RESET;
    else if (vlim_wr)
      volt_limit_q <= cmd_data;
  end

  // no clamping: an out-of-limit value leaves the output where it was
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      volt_q <= `SRR_VOLT_RESET;
    else if (volt_wr && volt_ok)
      volt_q <= cmd_data;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      err_post_q <= 1'b0;
      err_code_q <= 16'h0000;
    end
    else if (volt_wr && !volt_ok)
    begin
      err_post_q <= 1'b1;
      err_code_q <= `SRR_ERR_VLIMIT;
    end
    else if (addr_wr && !addr_ok)
    begin
      err_post_q <= 1'b1;
      err_code_q <= `SRR_ERR_RANGE;
    end
    else
      err_post_q <= 1'b0;
  end

  srr_beep_pulse u_beep (
    .sys_clk (sys_clk),
    .rst     (rst),
    .start   (beep_cmd),
    .tone    (beep_tone)
  );

  // ****************************************************************
  // query responses
  // ****************************************************************
  logic        rd_hit;
  logic [15:0] rd_data;
  logic        rsp_valid_q;
  logic [15:0] rsp_data_q;

  always_comb
  begin
    rd_hit  = 1'b1;
    rd_data = 16'h0000;
    case (cmd_code)
      srr_pkg::SRR_OPER_COND_RD: rd_data = oper_live;
      srr_pkg::SRR_OPER_ENAB_RD: rd_data = oper_mask_q;
      srr_pkg::SRR_OPER_EVT_RD:  rd_data = oper_evt;
      srr_pkg::SRR_QUES_EVT_RD:  rd_data = ques_evt;
      srr_pkg::SRR_QUES_COND_RD: rd_data = ques_live;
      srr_pkg::SRR_QUES_ENAB_RD: rd_data = ques_mask_q;
      srr_pkg::SRR_ADDR_RD:      rd_data = {11'h000, addr_q};
      srr_pkg::SRR_VOLT_RD:      rd_data = volt_q;
      srr_pkg::SRR_VLIM_RD:      rd_data = volt_limit_q;
      default:                   rd_hit  = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      rsp_valid_q <= 1'b0;
      rsp_data_q  <= 16'h0000;
    end
    else
    begin
      rsp_valid_q <= cmd_valid && rd_hit;
      if (cmd_valid && rd_hit)
        rsp_data_q <= rd_data;
    end
  end

  assign rsp_valid    = rsp_valid_q;
  assign rsp_data     = rsp_data_q;
  assign status_byte  = status_q;
  assign bus_address  = addr_q;
  assign volt_setting = volt_q;
  assign volt_limit   = volt_limit_q;
  assign err_post     = err_post_q;
  assign err_code     = err_code_q;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  oper_live_rd_a: assert property (
    cmd_is(cmd_valid, cmd_code, srr_pkg::SRR_OPER_COND_RD)
    |=> rsp_valid && rsp_data == $past(oper_live))
    else $error("operation condition read mismatch");
  regulation_bits_a: assert property (
    ##1 oper_live[10] == const_current_active && oper_live[8] == const_voltage_active)
    else $error("regulation mode bit wrong");
  trigger_cal_bits_a: assert property (
    oper_live[5] == awaiting_trigger && oper_live[0] == cal_computing)
    else $error("trigger wait or calibration bit wrong");
  unused_zero_a: assert property (
    ((oper_evt | oper_mask_q | oper_live) & 16'hFADE) == 16'h0000
    && ((ques_evt | ques_mask_q | ques_live) & 16'hFFF7) == 16'h0000)
    else $error("unused status bit set");
  oper_rd_clear_a: assert property (
    oper_evt_rd ##1 oper_evt != 16'h0000 |-> $past(oper_rise) == oper_evt)
    else $error("operation events not cleared by read");
  oper_summary_a: assert property (
    ##1 status_byte[7] == $past(|(oper_evt & oper_mask_q)))
    else $error("operation summary bit wrong");
  oper_mask_rw_a: assert property (
    oper_mask_wr && !preset
    |=> oper_mask_q == ($past(cmd_data) & 16'h0521))
    else $error("operation mask not stored");
  overtemp_cond_a: assert property (
    ques_live == {12'h000, overtemp_flag, 3'h0})
    else $error("questionable condition wrong");
  ques_rd_clear_a: assert property (
    ques_evt_rd && ques_rise == 16'h0000 |=> ques_evt == 16'h0000)
    else $error("questionable events not cleared by read");
  ques_summary_a: assert property (
    ##1 status_byte[3] == $past(|(ques_evt & ques_mask_q)))
    else $error("questionable summary bit wrong");
  ques_mask_rw_a: assert property (
    ques_mask_wr |=> ques_mask_q == ($past(cmd_data) & 16'h0008) || $past(preset))
    else $error("questionable mask not stored");
  preset_clear_a: assert property (
    preset ##1 !oper_mask_wr && !ques_mask_wr
    |-> oper_mask_q == 16'h0000 && ques_mask_q == 16'h0000
    ##1 status_byte == 8'h00)
    else $error("preset left reporting active");
  overtemp_hold_a: assert property (
    ques_evt[3] && !ques_evt_rd && !preset |=> ques_evt[3])
    else $error("overtemperature event lost before read");
  rise_set_a: assert property (
    (oper_rise[10] |=> oper_evt[10]) and (ques_rise[3] |=> ques_evt[3]))
    else $error("event not set on rising condition");
  addr_store_a: assert property (
    addr_wr |=> bus_address == ($past(addr_ok) ? $past(cmd_data[4:0])
                                                : $past(bus_address)))
    else $error("bus address handling wrong");
  beep_pulse_a: assert property (
    beep_cmd |=> beep_tone [*8])
    else $error("beep pulse missing");
  volt_reject_a: assert property (
    volt_wr && cmd_data > volt_limit
    |=> $stable(volt_setting) && err_post && err_code == 16'hFED3)
    else $error("over-limit voltage not rejected");

  oper_event_c: cover property (oper_rise[10] ##1 oper_evt_rd ##1 rsp_data[10]);
  overtemp_trip_c: cover property (ques_rise[3] ##2 status_byte[3]);
  preset_c:     cover property (status_byte[7] ##1 preset ##2 !status_byte[7]);
  reject_c:     cover property (volt_wr && !volt_ok ##1 err_post);

endmodule : srr_status_regs

// ===== verilog/srr_defs.svh
`ifndef SRR_DEFS_SVH
`define SRR_DEFS_SVH

// ****************************************************************
// operation group layout
// ****************************************************************
`define SRR_OPER_CAL_BIT     0
`define SRR_OPER_TRIG_WAIT_BIT 5
`define SRR_OPER_VREG_BIT    8
`define SRR_OPER_IREG_BIT    10
`define SRR_OPER_USED_MASK   16'h0521

// ****************************************************************
// questionable group layout
// ****************************************************************
`define SRR_QUES_OVERTEMP_BIT 3
`define SRR_QUES_USED_MASK   16'h0008

// ****************************************************************
// status byte and reset values
// ****************************************************************
`define SRR_STB_OPER_BIT     7
`define SRR_STB_QUES_BIT     3
`define SRR_MASK_RESET       16'h0000
`define SRR_ADDR_RESET       5'h01
`define SRR_ADDR_MIN         5'h01
`define SRR_ADDR_MAX         5'h1E
`define SRR_VOLT_RESET       16'h0000
`define SRR_VLIM_RESET       16'hFFFF
`define SRR_ERR_RANGE        16'hFF22
`define SRR_ERR_VLIMIT       16'hFED3

// ****************************************************************
// timing
// ****************************************************************
`define SRR_CLK_NS           20
`define SRR_TICK_NS          1000
`define SRR_TICK_CYCLES      (`SRR_TICK_NS / `SRR_CLK_NS)
`define SRR_BEEP_US          1000
`define SRR_BEEP_TICKS       ((`SRR_BEEP_US * 1000) / `SRR_TICK_NS)

`endif

// ===== verilog/srr_pkg.sv
package srr_pkg;

  // ****************************************************************
  // decoded host commands
  // ****************************************************************
  typedef enum logic [3:0] {
    SRR_OPER_COND_RD = 4'h0,
    SRR_OPER_ENAB_WR = 4'h1,
    SRR_OPER_ENAB_RD = 4'h2,
    SRR_OPER_EVT_RD  = 4'h3,
    SRR_QUES_EVT_RD  = 4'h4,
    SRR_QUES_COND_RD = 4'h5,
    SRR_QUES_ENAB_WR = 4'h6,
    SRR_QUES_ENAB_RD = 4'h7,
    SRR_PRESET       = 4'h8,
    SRR_BEEP         = 4'h9,
    SRR_ADDR_WR      = 4'hA,
    SRR_ADDR_RD      = 4'hB,
    SRR_VOLT_WR      = 4'hC,
    SRR_VOLT_RD      = 4'hD,
    SRR_VLIM_WR      = 4'hE,
    SRR_VLIM_RD      = 4'hF
  } srr_cmd_e;

  typedef enum logic [1:0] {
    SRR_BEEP_IDLE  = 2'b01,
    SRR_BEEP_SOUND = 2'b10
  } srr_beep_state_e;

endpackage : srr_pkg

// ===== verilog/srr_beep_pulse.sv
`timescale 1ns/1ns
`include "srr_defs.svh"

module srr_beep_pulse (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic start,
  output logic      tone
);

  // ****************************************************************
  // microsecond tick divider
  // ****************************************************************
  localparam logic [5:0]  TICK_LAST = 6'(`SRR_TICK_CYCLES - 1);
  localparam logic [10:0] BEEP_LAST = 11'(`SRR_BEEP_TICKS - 1);

  logic [5:0]             div_q;
  logic                   tick_q;
  logic [10:0]            len_q;
  srr_pkg::srr_beep_state_e state_q;

  always_ff @(posedge sys_clk)
  begin
    if (rst || start || div_q == TICK_LAST)
    begin
      div_q  <= 6'h00;
      tick_q <= !(rst || start);
    end
    else
    begin
      div_q  <= div_q + 6'h01;
      tick_q <= 1'b0;
    end
  end

  // ****************************************************************
  // tone state
  // ****************************************************************
  // a new start restarts the tone rather than queuing a second one
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      state_q <= srr_pkg::SRR_BEEP_IDLE;
      len_q   <= 11'h000;
      tone    <= 1'b0;
    end
    else if (start)
    begin
      state_q <= srr_pkg::SRR_BEEP_SOUND;
      len_q   <= 11'h000;
      tone    <= 1'b1;
    end
    else
    begin
      case (state_q)
        srr_pkg::SRR_BEEP_SOUND:
        begin
          if (tick_q && len_q == BEEP_LAST)
          begin
            state_q <= srr_pkg::SRR_BEEP_IDLE;
            tone    <= 1'b0;
          end
          else if (tick_q)
            len_q <= len_q + 11'h001;
        end
        default:
        begin
          state_q <= srr_pkg::SRR_BEEP_IDLE;
          tone    <= 1'b0;
        end
      endcase
    end
  end

endmodule : srr_beep_pulse

// ===== testbench/srr_host_model.sv
`timescale 1ns/1ns

// ********
// remote host: one command at a time
// ********
module srr_host_model (
  input  wire logic         sys_clk,
  input  wire logic         rsp_valid,
  input  wire logic [15:0]  rsp_data,
  input  wire logic         err_post,
  output logic              cmd_valid,
  output srr_pkg::srr_cmd_e cmd_code,
  output logic [15:0]       cmd_data
);
  initial
  begin
    cmd_valid = 1'b0;
    cmd_code  = srr_pkg::SRR_OPER_COND_RD;
    cmd_data  = 16'h0000;
  end

  // answer or error is caught within four cycles, writes just time out quietly
  task automatic issue(
    input  srr_pkg::srr_cmd_e code,
    input  logic [15:0]       data,
    output logic [15:0]       got,
    output logic              seen
  );
    int n;
    @(negedge sys_clk);
    cmd_valid = 1'b1;
    cmd_code  = code;
    cmd_data  = data;
    got       = 16'h0000;
    seen      = 1'b0;
    for (n = 0; n < 4 && !seen; n++)
    begin
      @(negedge sys_clk);
      if (n == 0)
      begin
        cmd_valid = 1'b0;
        // released data must not look valid
        cmd_data  = ~cmd_data;
      end
      if (rsp_valid === 1'b1 || err_post === 1'b1)
      begin
        seen = 1'b1;
        got  = rsp_data;
      end
    end
  endtask : issue
endmodule : srr_host_model

// ===== testbench/testbench.sv
`timescale 1ns/1ns

module testbench;
  logic              sys_clk;
  logic              rst;
  logic              cmd_valid;
  srr_pkg::srr_cmd_e cmd_code;
  logic [15:0]       cmd_data;
  logic [4:0]        cond;
  logic              rsp_valid;
  logic [15:0]       rsp_data;
  logic [7:0]        status_byte;
  logic [4:0]        bus_address;
  logic              beep_tone;
  logic [15:0]       volt_setting;
  logic [15:0]       volt_limit;
  logic              err_post;
  logic [15:0]       err_code;
  logic [15:0]       got;
  logic              seen;
  int                mismatches;
  int                compares;
  int                i;
  int                n;
  int                pos[4] = '{0, 5, 8, 10};

  srr_status_regs dut (
    .sys_clk(sys_clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_data(cmd_data), .const_current_active(cond[3]), .const_voltage_active(cond[2]),
    .awaiting_trigger(cond[1]), .cal_computing(cond[0]), .overtemp_flag(cond[4]),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .status_byte(status_byte),
    .bus_address(bus_address), .beep_tone(beep_tone), .volt_setting(volt_setting),
    .volt_limit(volt_limit), .err_post(err_post), .err_code(err_code)
  );

  srr_host_model host (
    .sys_clk(sys_clk), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .err_post(err_post),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_data(cmd_data)
  );

  // ********
  // checking helpers
  // ********
  task automatic report_and_stop();
    if (mismatches == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop

  task automatic check(input string what, input logic [15:0] seen_v, input logic [15:0] exp);
    compares++;
    if (seen_v !== exp)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen_v);
    end
  endtask : check

  task automatic cmd(input srr_pkg::srr_cmd_e code, input logic [15:0] data);
    host.issue(code, data, got, seen);
  endtask : cmd

  // a missing answer ends the run at once
  task automatic rd(input srr_pkg::srr_cmd_e code, input logic [15:0] exp);
    host.issue(code, 16'h0000, got, seen);
    check("answered", {15'h0000, seen}, 16'h0001);
    if (seen !== 1'b1)
      report_and_stop();
    else
      check(code.name(), got, exp);
  endtask : rd

  task automatic err_is(input logic [15:0] code);
    check("err_seen", {15'h0000, seen}, 16'h0001);
    check("err_code", err_code, code);
  endtask : err_is

  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // ********
  // main sequence
  // ********
  initial
  begin
    mismatches = 0;
    compares   = 0;
    rst        = 1'b1;
    cond       = 5'h00;
    repeat (4) @(negedge sys_clk);
    rst = 1'b0;
    @(negedge sys_clk);
    check("volt_limit", volt_limit, 16'hFFFF);
    check("address", {11'h000, bus_address}, 16'h0001);
    check("status", {8'h00, status_byte}, 16'h0000);
    rd(srr_pkg::SRR_OPER_ENAB_RD, 16'h0000);
    cmd(srr_pkg::SRR_OPER_ENAB_WR, 16'h0521);
    rd(srr_pkg::SRR_OPER_ENAB_RD, 16'h0521);
    cmd(srr_pkg::SRR_OPER_ENAB_WR, 16'hFFFF);
    rd(srr_pkg::SRR_OPER_ENAB_RD, 16'h0521);
    for (i = 0; i < 4; i++)
    begin
      cond[i] = 1'b1;
      @(negedge sys_clk);
      rd(srr_pkg::SRR_OPER_COND_RD, 16'h0001 << pos[i]);
      rd(srr_pkg::SRR_OPER_EVT_RD, 16'h0001 << pos[i]);
      rd(srr_pkg::SRR_OPER_EVT_RD, 16'h0000);
      cond[i] = 1'b0;
    end
    cmd(srr_pkg::SRR_OPER_ENAB_WR, 16'h0400);
    cond[2] = 1'b1;
    repeat (3) @(negedge sys_clk);
    check("summary_off", {8'h00, status_byte}, 16'h0000);
    cond[3] = 1'b1;
    repeat (3) @(negedge sys_clk);
    check("summary_on", {8'h00, status_byte}, 16'h0080);
    rd(srr_pkg::SRR_OPER_EVT_RD, 16'h0500);
    repeat (3) @(negedge sys_clk);
    check("summary_clr", {8'h00, status_byte}, 16'h0000);
    cond[3:2] = 2'b00;
    cmd(srr_pkg::SRR_QUES_ENAB_WR, 16'hFFFF);
    rd(srr_pkg::SRR_QUES_ENAB_RD, 16'h0008);
    cond[4] = 1'b1;
    repeat (10) @(negedge sys_clk);
    check("ques_sum", {8'h00, status_byte}, 16'h0008);
    rd(srr_pkg::SRR_QUES_COND_RD, 16'h0008);
    rd(srr_pkg::SRR_QUES_EVT_RD, 16'h0008);
    rd(srr_pkg::SRR_QUES_EVT_RD, 16'h0000);
    rd(srr_pkg::SRR_QUES_COND_RD, 16'h0008);
    cond[4] = 1'b0;
    @(negedge sys_clk);
    cond[4] = 1'b1;
    cmd(srr_pkg::SRR_OPER_ENAB_WR, 16'h0521);
    cmd(srr_pkg::SRR_PRESET, 16'h0000);
    repeat (3) @(negedge sys_clk);
    check("preset_sum", {8'h00, status_byte}, 16'h0000);
    rd(srr_pkg::SRR_QUES_ENAB_RD, 16'h0000);
    rd(srr_pkg::SRR_OPER_ENAB_RD, 16'h0000);
    rd(srr_pkg::SRR_QUES_EVT_RD, 16'h0000);
    cond[4] = 1'b0;
    cmd(srr_pkg::SRR_ADDR_WR, 16'h001E);
    rd(srr_pkg::SRR_ADDR_RD, 16'h001E);
    cmd(srr_pkg::SRR_ADDR_WR, 16'h001F);
    err_is(16'hFF22);
    cmd(srr_pkg::SRR_ADDR_WR, 16'h0000);
    err_is(16'hFF22);
    rd(srr_pkg::SRR_ADDR_RD, 16'h001E);
    cmd(srr_pkg::SRR_VLIM_WR, 16'h012C);
    rd(srr_pkg::SRR_VLIM_RD, 16'h012C);
    cmd(srr_pkg::SRR_VOLT_WR, 16'h00DD);
    cmd(srr_pkg::SRR_VOLT_WR, 16'h014D);
    err_is(16'hFED3);
    rd(srr_pkg::SRR_VOLT_RD, 16'h00DD);
    cmd(srr_pkg::SRR_VOLT_WR, 16'h012C);
    check("volt_edge", volt_setting, 16'h012C);
    check("volt_edge_err", {15'h0000, seen}, 16'h0000);
    cmd(srr_pkg::SRR_BEEP, 16'h0000);
    check("beep_on", {15'h0000, beep_tone}, 16'h0001);
    n = 0;
    while (beep_tone === 1'b1 && n < 60000)
    begin
      @(negedge sys_clk);
      n++;
    end
    check("beep_len", {15'h0000, (n > 49800 && n < 50100)}, 16'h0001);
    report_and_stop();
  end
endmodule : testbench
